/* File: src/asr_defines.svh */
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// Word offsets on the serial register port
`define ASR_OFS_CTRL 8'h1E
`define ASR_OFS_ANGLE 8'h20
`define ASR_OFS_STATUS 8'h22
`define ASR_OFS_ERROR 8'h24

// Fixed word identifiers in bits 15:12
`define ASR_RID_STATUS 4'h8
`define ASR_RID_ERROR 4'hA

// Control word fields
`define ASR_CTRL_SEL_HI 15
`define ASR_CTRL_SEL_LO 12
`define ASR_CTRL_CLS 10
`define ASR_CTRL_CLW 9
`define ASR_CTRL_CLE 8
`define ASR_CTRL_INIT_HI 7
`define ASR_CTRL_INIT_LO 0

// Initiate codes
`define ASR_INIT_SELFTEST 8'hB9
`define ASR_INIT_TURNS 8'h46
`define ASR_INIT_HARDRST 8'h5A

// Special-action selections
`define ASR_SEL_NONE 4'h0
`define ASR_SEL_MARGIN_LO 4'h1
`define ASR_SEL_MARGIN_HI 4'h2
`define ASR_SEL_TURNS 4'h4
`define ASR_SEL_HARDRST 4'h7
`define ASR_SEL_FRONTEND 4'h9
`define ASR_SEL_LOGIC 4'hA
`define ASR_SEL_BOTH 4'hB

// Error word layout and reset value (reset flag set at power-on)
`define ASR_ERR_BITS 12
`define ASR_ERR_RESET_VAL 12'h001

`endif

/* File: src/asr_pkg.sv */
package asr_pkg;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [15:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } asr_rsp_t;

    typedef enum logic {
        ACT_IDLE,
        ACT_BUSY
    } asr_act_state_t;

endpackage : asr_pkg

/* File: src/asr_err_bank.sv */
`timescale 1ns/1ps
`include "asr_defines.svh"

module asr_err_bank #(
    parameter int WIDTH = `ASR_ERR_BITS,
    parameter logic [WIDTH-1:0] RESET_VAL = `ASR_ERR_RESET_VAL
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] evt,
    input wire logic read_stb,
    input wire logic clear_stb,
    output logic [WIDTH-1:0] flags_q
);

    logic [WIDTH-1:0] seen_q;

    // Bits returned by the latest read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= '0;
        end else if (read_stb) begin
            seen_q <= flags_q;
        end else if (clear_stb) begin
            seen_q <= '0;
        end
    end

    // Sticky flags; a new event wins over the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= RESET_VAL;
        end else if (clear_stb) begin
            flags_q <= (flags_q & ~seen_q) | evt;
        end else begin
            flags_q <= flags_q | evt;
        end
    end

endmodule : asr_err_bank

/* File: src/asr_regs.sv */
// Overview of operation
// - Control clear-error bit clears only error bits already read; reads as 0.
// - Initiate codes B9 self-tests, 46 turns reset, 5A hard reset; read 0.
// - Angle word: 0, error flag, undervoltage, parity, 12-bit angle.
// - Angle error flag is 1 when any unmasked error or warning bit set.
// - Angle undervoltage bit is live OR of pin and regulator detectors, maskable.
// - Angle parity makes the whole 16-bit word hold odd ones.
// - Bits 15:12 identify the word: 1000 status, 1010 error.
// - Status bits 9:8 show the die identifier from nonvolatile memory.
// - Status bit 7 shows rotation direction from the hysteresis logic.
// - Action-done clears on trigger, sets on completion, clears by status-clear.
// - Boot-done sets after boot and self-tests, held until status-clear.
// - Status bits 3, 2, 1 show logic test, front-end test, boot running.
// - Status bit 0 is 1 only when locked and start-up finished.
// - Error flags latch until read and cleared; host must clear them.
// - Reset error flag is set after power-on; host should clear it.
// - Error bit 11 sets on unmasked warnings, suppressible by a mask bit.
// - Error bit 10 sets when either self-test reports failure.
// - Error bit 9 sets when averaging rate is too high for speed.
// - Error bit 8 on quadrature integrity loss, bit 7 on lock loss.
// - Error bit 6 on zero-cross timeout, bit 4 on oscillator watchdog.
// - Error bit 5 on uncorrectable memory error during load.
// - Error bit 3 re-sets while supply-pin undervoltage persists.
// - Error bit 0 sets on power-on or hard reset, not logic test.
// - Special selection returns to zero on completion, except margining.
`timescale 1ns/1ps
`include "asr_defines.svh"

module asr_regs
    import asr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire asr_req_t bus_req,
    output asr_rsp_t bus_rsp,
    input wire logic [11:0] angle_code,
    input wire logic warn_any_unmasked,
    input wire logic warn_summary_mask,
    input wire logic [11:0] err_mask,
    input wire logic supply_pin_low_flag,
    input wire logic regulator_low_flag,
    input wire logic supply_pin_low_mask,
    input wire logic regulator_low_mask,
    input wire logic [1:0] die_identifier,
    input wire logic turn_direction,
    input wire logic logic_selftest_running,
    input wire logic frontend_selftest_running,
    input wire logic boot_running,
    input wire logic boot_finished,
    input wire logic tracking_locked,
    input wire logic startup_complete,
    input wire logic selftest_failed,
    input wire logic averaging_fault,
    input wire logic quadrature_integrity_fault,
    input wire logic tracking_lock_lost,
    input wire logic zero_cross_timeout,
    input wire logic nvm_uncorrectable,
    input wire logic hf_osc_fault,
    input wire logic lf_osc_fault,
    input wire logic magnetic_low_fault,
    input wire logic hard_reset_done,
    input wire logic action_complete,
    output logic [3:0] special_select_q,
    output logic logic_selftest_start_q,
    output logic frontend_selftest_start_q,
    output logic turns_reset_start_q,
    output logic hard_reset_request_q,
    output logic warning_clear_q
);

    logic [11:0] err_flags;
    logic [11:0] err_evt;
    logic err_read;
    logic err_clear;
    logic ctrl_wr;
    logic [3:0] wr_sel;
    logic [7:0] wr_init;
    logic trigger;
    logic action_done_q;
    logic boot_done_q;
    logic status_clear;
    asr_act_state_t act_state_q;
    logic any_fault_flag;
    logic low_supply_flag;
    logic [15:0] angle_word;
    logic [15:0] status_word;
    logic [15:0] error_word;
    logic [15:0] ctrl_word;
    logic [15:0] rdata_d;

    // Odd parity bit over the given payload
    function automatic logic odd_parity(input logic [13:0] payload);
        odd_parity = ~(^payload);
    endfunction : odd_parity

    // Selections started by the self-test initiate code
    function automatic logic is_selftest_sel(input logic [3:0] sel);
        is_selftest_sel = (sel == `ASR_SEL_FRONTEND)
            || (sel == `ASR_SEL_LOGIC)
            || (sel == `ASR_SEL_BOTH);
    endfunction : is_selftest_sel

    // Selections kept after completion
    function automatic logic is_margin_sel(input logic [3:0] sel);
        is_margin_sel = (sel == `ASR_SEL_MARGIN_LO)
            || (sel == `ASR_SEL_MARGIN_HI);
    endfunction : is_margin_sel

    assign ctrl_wr = bus_req.valid && bus_req.write
        && (bus_req.addr == `ASR_OFS_CTRL);
    assign err_read = bus_req.valid && !bus_req.write
        && (bus_req.addr == `ASR_OFS_ERROR);
    assign wr_sel = bus_req.wdata[`ASR_CTRL_SEL_HI:`ASR_CTRL_SEL_LO];
    assign wr_init = bus_req.wdata[`ASR_CTRL_INIT_HI:`ASR_CTRL_INIT_LO];
    assign err_clear = ctrl_wr && bus_req.wdata[`ASR_CTRL_CLE];
    assign status_clear = ctrl_wr && bus_req.wdata[`ASR_CTRL_CLS];

    // A valid initiate code for the written selection
    always_comb begin
        trigger = 1'b0;
        if (ctrl_wr && act_state_q == ACT_IDLE) begin
            if (is_selftest_sel(wr_sel)) begin
                trigger = (wr_init == `ASR_INIT_SELFTEST);
            end else if (wr_sel == `ASR_SEL_TURNS) begin
                trigger = (wr_init == `ASR_INIT_TURNS);
            end else if (wr_sel == `ASR_SEL_HARDRST) begin
                trigger = (wr_init == `ASR_INIT_HARDRST);
            end
        end
    end

    // Error event sources
    always_comb begin
        err_evt = '0;
        err_evt[11] = warn_any_unmasked && !warn_summary_mask;
        err_evt[10] = selftest_failed;
        err_evt[9] = averaging_fault;
        err_evt[8] = quadrature_integrity_fault;
        err_evt[7] = tracking_lock_lost;
        err_evt[6] = zero_cross_timeout;
        err_evt[5] = nvm_uncorrectable;
        err_evt[4] = hf_osc_fault || lf_osc_fault;
        err_evt[3] = supply_pin_low_flag;
        err_evt[2] = regulator_low_flag;
        err_evt[1] = magnetic_low_fault;
        err_evt[0] = hard_reset_done;
    end

    asr_err_bank #(
        .WIDTH(`ASR_ERR_BITS),
        .RESET_VAL(`ASR_ERR_RESET_VAL)
    ) u_err_bank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .evt(err_evt),
        .read_stb(err_read),
        .clear_stb(err_clear),
        .flags_q(err_flags)
    );

    // Special-action sequencing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            act_state_q <= ACT_IDLE;
        end else begin
            case (act_state_q)
                ACT_IDLE: begin
                    if (trigger) begin
                        act_state_q <= ACT_BUSY;
                    end
                end
                ACT_BUSY: begin
                    if (action_complete) begin
                        act_state_q <= ACT_IDLE;
                    end
                end
                default: begin
                    act_state_q <= ACT_IDLE;
                end
            endcase
        end
    end

    // Selection field
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            special_select_q <= `ASR_SEL_NONE;
        end else if (act_state_q == ACT_BUSY && action_complete
                     && !is_margin_sel(special_select_q)) begin
            special_select_q <= `ASR_SEL_NONE;
        end else if (ctrl_wr && act_state_q == ACT_IDLE) begin
            special_select_q <= wr_sel;
        end
    end

    // Launch pulses towards the action logic
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            logic_selftest_start_q <= 1'b0;
            frontend_selftest_start_q <= 1'b0;
            turns_reset_start_q <= 1'b0;
            hard_reset_request_q <= 1'b0;
        end else begin
            logic_selftest_start_q <= trigger
                && ((wr_sel == `ASR_SEL_LOGIC) || (wr_sel == `ASR_SEL_BOTH));
            frontend_selftest_start_q <= trigger
                && ((wr_sel == `ASR_SEL_FRONTEND)
                    || (wr_sel == `ASR_SEL_BOTH));
            turns_reset_start_q <= trigger && (wr_sel == `ASR_SEL_TURNS);
            hard_reset_request_q <= trigger && (wr_sel == `ASR_SEL_HARDRST);
        end
    end

    // Warning-clear pulse to the warning word owner
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            warning_clear_q <= 1'b0;
        end else begin
            warning_clear_q <= ctrl_wr && bus_req.wdata[`ASR_CTRL_CLW];
        end
    end

    // Action-done flag; completion wins over clears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            action_done_q <= 1'b0;
        end else if (act_state_q == ACT_BUSY && action_complete) begin
            action_done_q <= 1'b1;
        end else if (trigger || status_clear) begin
            action_done_q <= 1'b0;
        end
    end

    // Boot-done flag; boot finish wins over the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot_done_q <= 1'b0;
        end else if (boot_finished) begin
            boot_done_q <= 1'b1;
        end else if (status_clear) begin
            boot_done_q <= 1'b0;
        end
    end

    // Live angle-word flags
    assign any_fault_flag = (|(err_flags & ~err_mask))
        || warn_any_unmasked;
    assign low_supply_flag = (supply_pin_low_flag && !supply_pin_low_mask)
        || (regulator_low_flag && !regulator_low_mask);

    // Read words
    always_comb begin
        angle_word = '0;
        angle_word[14] = any_fault_flag;
        angle_word[13] = low_supply_flag;
        angle_word[11:0] = angle_code;
        angle_word[12] = odd_parity({any_fault_flag, low_supply_flag,
            angle_code});
    end

    always_comb begin
        status_word = '0;
        status_word[15:12] = `ASR_RID_STATUS;
        status_word[9:8] = die_identifier;
        status_word[7] = turn_direction;
        status_word[5] = action_done_q;
        status_word[4] = boot_done_q;
        status_word[3] = logic_selftest_running;
        status_word[2] = frontend_selftest_running;
        status_word[1] = boot_running;
        status_word[0] = tracking_locked && startup_complete;
    end

    always_comb begin
        error_word = '0;
        error_word[15:12] = `ASR_RID_ERROR;
        error_word[11:0] = err_flags;
    end

    // Clear and initiate fields always read as zero
    always_comb begin
        ctrl_word = '0;
        ctrl_word[`ASR_CTRL_SEL_HI:`ASR_CTRL_SEL_LO] = special_select_q;
    end

    // Read decode
    always_comb begin
        if (bus_req.addr == `ASR_OFS_ANGLE) begin
            rdata_d = angle_word;
        end else if (bus_req.addr == `ASR_OFS_STATUS) begin
            rdata_d = status_word;
        end else if (bus_req.addr == `ASR_OFS_ERROR) begin
            rdata_d = error_word;
        end else if (bus_req.addr == `ASR_OFS_CTRL) begin
            rdata_d = ctrl_word;
        end else begin
            rdata_d = '0;
        end
    end

    // Registered response, one cycle after a read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp.valid <= bus_req.valid && !bus_req.write;
            if (bus_req.valid && !bus_req.write) begin
                bus_rsp.rdata <= rdata_d;
            end
        end
    end

endmodule : asr_regs

/* File: tb/asr_host.sv */
`timescale 1ns/1ps
module asr_host
    import asr_pkg::*;
(
    input wire logic clk_sys,
    output asr_req_t bus_req,
    input wire asr_rsp_t bus_rsp
);
    int gap = 0;
    initial bus_req = '0;
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [15:0] d, output logic [15:0] q);
        repeat (gap + 1) @(posedge clk_sys);
        bus_req <= '{1'b1, w, a, d};
        @(posedge clk_sys);
        // Released lines show inverted data, not a held copy
        bus_req <= '{1'b0, ~w, ~a, ~d};
        #1;
        q = bus_rsp.valid ? bus_rsp.rdata : 16'hXXXX;
    endtask : xfer
endmodule : asr_host

/* File: tb/asr_regs_asserts.sv */
`timescale 1ns/1ps
module asr_regs_asserts
    import asr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire asr_req_t bus_req,
    input wire asr_rsp_t bus_rsp,
    input wire logic [11:0] angle_code,
    input wire logic [1:0] die_identifier,
    input wire logic turn_direction,
    input wire logic action_complete,
    input wire logic [3:0] special_select_q,
    input wire logic logic_selftest_start_q,
    input wire logic frontend_selftest_start_q,
    input wire logic turns_reset_start_q,
    input wire logic hard_reset_request_q,
    input wire logic warning_clear_q
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic rd_now;
    logic ctl_wr;
    assign rd_now = bus_req.valid && !bus_req.write;
    assign ctl_wr = bus_req.valid && bus_req.write && bus_req.addr == 8'h1E;
    a_read_answer: assert property (rd_now |=> bus_rsp.valid)
        else $error("read got no answer");
    a_angle_word: assert property (
        rd_now && bus_req.addr == 8'h20 |=> !bus_rsp.rdata[15]
        && ^bus_rsp.rdata && bus_rsp.rdata[11:0] == $past(angle_code))
        else $error("angle word wrong");
    a_status_word: assert property (
        rd_now && bus_req.addr == 8'h22 |=>
        bus_rsp.rdata[15:10] == 6'h20 && !bus_rsp.rdata[6]
        && bus_rsp.rdata[9:7] == {$past(die_identifier), $past(turn_direction)})
        else $error("status fixed fields wrong");
    a_error_id: assert property (
        rd_now && bus_req.addr == 8'h24 |=> bus_rsp.rdata[15:12] == 4'hA)
        else $error("error word id wrong");
    a_ctrl_reads: assert property (
        rd_now && bus_req.addr == 8'h1E |=> bus_rsp.rdata[11:0] == 12'h000)
        else $error("control low bits not zero");
    a_test_launch: assert property (
        ctl_wr && bus_req.wdata == 16'hB0B9 && special_select_q == 4'h0 |=>
        logic_selftest_start_q && frontend_selftest_start_q
        && special_select_q == 4'hB)
        else $error("self-test not launched");
    a_turns_launch: assert property (
        ctl_wr && bus_req.wdata == 16'h4046 && special_select_q == 4'h0 |=>
        turns_reset_start_q ##1 !turns_reset_start_q)
        else $error("turns reset pulse wrong");
    a_hard_launch: assert property (
        ctl_wr && bus_req.wdata == 16'h705A && special_select_q == 4'h0 |=>
        hard_reset_request_q ##1 !hard_reset_request_q)
        else $error("hard reset pulse wrong");
    a_select_return: assert property (
        action_complete && special_select_q inside {4'h4, 4'h7, 4'hB}
        |=> special_select_q == 4'h0)
        else $error("selection not returned to zero");
    a_warn_clear: assert property (
        ctl_wr |=> warning_clear_q == $past(bus_req.wdata[9]))
        else $error("warning clear pulse wrong");
endmodule : asr_regs_asserts

bind asr_regs asr_regs_asserts i_chk (
    .clk_sys, .rst_n, .bus_req, .bus_rsp, .angle_code, .die_identifier,
    .turn_direction, .action_complete, .special_select_q,
    .logic_selftest_start_q, .frontend_selftest_start_q,
    .turns_reset_start_q, .hard_reset_request_q, .warning_clear_q);

/* File: tb/asr_regs_tb_top.sv */
`timescale 1ns/1ps
module asr_regs_tb_top
    import asr_pkg::*;
;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    asr_req_t bus_req;
    asr_rsp_t bus_rsp;
    logic [11:0] angle_code = 12'h000, err_mask = 12'h000;
    logic [1:0] die_identifier = 2'h2;
    logic turn_direction = 1'b1, warn_summary_mask = 1'b0;
    logic supply_pin_low_mask = 1'b1, regulator_low_mask = 1'b0;
    logic logic_selftest_running = 1'b1, frontend_selftest_running = 1'b0;
    logic boot_running = 1'b1, boot_finished = 1'b0, action_complete = 1'b0;
    logic tracking_locked = 1'b1, startup_complete = 1'b0;
    logic [12:0] ev = 13'h0000;
    logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'h555, 12'h801};
    logic [15:0] acts [3] = '{16'hB0B9, 16'h4046, 16'h705A};
    int eb [13] = '{10, 9, 8, 7, 6, 5, 4, 4, 1, 0, 11, 3, 2};
    int mismatches = 0, n_compared = 0, cyc = 0;

    asr_regs i_dut (
        .clk_sys, .rst_n, .bus_req, .bus_rsp, .angle_code,
        .warn_any_unmasked(ev[10]), .warn_summary_mask, .err_mask,
        .supply_pin_low_flag(ev[11]), .regulator_low_flag(ev[12]),
        .supply_pin_low_mask, .regulator_low_mask, .die_identifier,
        .turn_direction, .logic_selftest_running, .frontend_selftest_running,
        .boot_running, .boot_finished, .tracking_locked, .startup_complete,
        .selftest_failed(ev[0]), .averaging_fault(ev[1]),
        .quadrature_integrity_fault(ev[2]), .tracking_lock_lost(ev[3]),
        .zero_cross_timeout(ev[4]), .nvm_uncorrectable(ev[5]),
        .hf_osc_fault(ev[6]), .lf_osc_fault(ev[7]),
        .magnetic_low_fault(ev[8]), .hard_reset_done(ev[9]),
        .action_complete, .special_select_q(), .logic_selftest_start_q(),
        .frontend_selftest_start_q(), .turns_reset_start_q(),
        .hard_reset_request_q(), .warning_clear_q());
    asr_host i_host (.clk_sys, .bus_req, .bus_rsp);

    initial forever #2.5 clk_sys = ~clk_sys;

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic rdx(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        i_host.xfer(1'b0, a, 16'h0000, q);
        n_compared++;
        if (q !== e) begin
            mismatches++;
            $display("FAIL word %h exp %h got %h", a, e, q);
        end
    endtask : rdx

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask : wr

    function automatic logic [15:0] angw(logic ef, logic uv, logic [11:0] c);
        return {1'b0, ef, uv, ~^{ef, uv, c}, c};
    endfunction : angw

    function automatic logic [15:0] stw(logic sd, logic bd);
        return {4'h8, 2'b00, die_identifier, turn_direction, 1'b0, sd, bd,
            logic_selftest_running, frontend_selftest_running, boot_running,
            tracking_locked & startup_complete};
    endfunction : stw

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdx(8'h22, stw(1'b0, 1'b0));
        rdx(8'h1E, 16'h0000);
        rdx(8'h30, 16'h0000);
        rdx(8'h24, 16'hA001);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            angle_code <= codes[k];
            err_mask <= {11'h000, k[0]};
            rdx(8'h20, angw(!k[0], 1'b0, codes[k]));
        end
        @(posedge clk_sys);
        ev[4] <= 1'b1;
        @(posedge clk_sys);
        ev[4] <= 1'b0;
        wr(8'h1E, 16'h0100);
        rdx(8'h24, 16'hA040);
        wr(8'h1E, 16'h0100);
        rdx(8'h24, 16'hA000);
        $display("test reset and angle done");
        for (int i = 0; i < 13; i++) begin
            @(posedge clk_sys);
            ev[i] <= 1'b1;
            @(posedge clk_sys);
            ev[i] <= 1'b0;
            rdx(8'h24, 16'hA000 | (16'h0001 << eb[i]));
            wr(8'h1E, 16'h0100);
            rdx(8'h24, 16'hA000);
        end
        $display("test error flags done");
        @(posedge clk_sys);
        ev[11] <= 1'b1;
        err_mask <= 12'h008;
        rdx(8'h20, angw(1'b0, 1'b0, 12'h801));
        @(posedge clk_sys);
        supply_pin_low_mask <= 1'b0;
        rdx(8'h20, angw(1'b0, 1'b1, 12'h801));
        rdx(8'h24, 16'hA008);
        wr(8'h1E, 16'h0100);
        rdx(8'h24, 16'hA008);
        @(posedge clk_sys);
        ev[11] <= 1'b0;
        rdx(8'h24, 16'hA008);
        wr(8'h1E, 16'h0100);
        rdx(8'h24, 16'hA000);
        wr(8'h1E, 16'h0200);
        rdx(8'h1E, 16'h0000);
        $display("test undervoltage done");
        i_host.gap = 3;
        for (int k = 0; k < 3; k++) begin
            wr(8'h1E, acts[k]);
            rdx(8'h1E, {acts[k][15:12], 12'h000});
            rdx(8'h22, stw(1'b0, 1'b0));
            @(posedge clk_sys);
            action_complete <= 1'b1;
            @(posedge clk_sys);
            action_complete <= 1'b0;
            rdx(8'h22, stw(1'b1, 1'b0));
            rdx(8'h1E, 16'h0000);
            wr(8'h1E, 16'h0400);
            rdx(8'h22, stw(1'b0, 1'b0));
        end
        $display("test special actions done");
        @(posedge clk_sys);
        {die_identifier, turn_direction, startup_complete} <= 4'h5;
        {logic_selftest_running, frontend_selftest_running} <= 2'h1;
        {boot_running, boot_finished} <= 2'h1;
        @(posedge clk_sys);
        boot_finished <= 1'b0;
        rdx(8'h22, stw(1'b0, 1'b1));
        wr(8'h1E, 16'h0400);
        rdx(8'h22, stw(1'b0, 1'b0));
        $display("test boot status done");
        close_out();
    end
endmodule : asr_regs_tb_top
